// File: cst_defs.svh
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// command codes
`define CST_STATUS_ADDR 8'h39
`define CST_VBAT_ADDR 8'h3A
`define CST_VIN_ADDR 8'h3B
`define CST_VOUT_ADDR 8'h3C
`define CST_IBAT_ADDR 8'h3D
`define CST_IIN_ADDR 8'h3E
`define CST_DIE_ADDR 8'h3F
`define CST_NTC_ADDR 8'h40
`define CST_BSR_ADDR 8'h41
`define CST_TELEM_BASE 8'h3A
`define CST_TELEM_LAST 8'h41

// telemetry channel numbers (offset from base)
`define CST_CH_IBAT 3'h3
`define CST_CH_NTC 3'h6

// live status bit positions
`define CST_ST_NO_FREQ_RES 5
`define CST_ST_THERMAL_SD 4
`define CST_ST_INPUT_OVLO 3
`define CST_ST_IN_GT_BAT 2
`define CST_ST_IN_GT_UVLO 1
`define CST_ST_INTSUP_OK 0

// layout of the synchronised pin vector
`define CST_SY_SCL 0
`define CST_SY_SDA 1
`define CST_SY_STATUS_LO 2
`define CST_SY_CHG_EN 8
`define CST_SY_WIDTH 9

// reset values and codes
`define CST_TELEM_RESET 16'h0000
`define CST_OPEN_NTC_CODE 16'h54B4
`define CST_NTC_FULL_SCALE 16'h5545
`define CST_I2C_ADDR_DEFAULT 7'h2A

`endif

// File: cst_host_model.sv
`timescale 1ns/100ps
module cst_host_model (
    // clock
    input wire logic clk_i,
    // bus lines, data is open drain
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // host-side ohms from a thermistor reading
    function automatic int ntc_ohms(input int bias, input int reading);
        return bias * reading / (21829 - reading);
    endfunction : ntc_ohms
    task automatic half;
        repeat (5) @(negedge clk_i);
    endtask : half
    // one clock of hold after the fall so data never moves near the edge
    task automatic put_bit(input logic b);
        @(negedge clk_i);
        sda_oe_o = ~b;
        repeat (4) @(negedge clk_i);
        scl_o = 1'b1;
        half();
        scl_o = 1'b0;
    endtask : put_bit
    task automatic get_bit(output logic b);
        @(negedge clk_i);
        sda_oe_o = 1'b0;
        repeat (4) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (3) @(negedge clk_i);
        b = sda_i;
        repeat (2) @(negedge clk_i);
        scl_o = 1'b0;
    endtask : get_bit
    task automatic start;
        @(negedge clk_i);
        sda_oe_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_oe_o = 1'b1;
        half();
        scl_o = 1'b0;
    endtask : start
    task automatic stop;
        @(negedge clk_i);
        sda_oe_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_oe_o = 1'b0;
        half();
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(nak);
    endtask : wbyte
    task automatic rbyte(output logic [7:0] d, input logic last);
        logic b;
        for (int i = 0; i < 8; i++) begin
            get_bit(b);
            d = {d[6:0], b};
        end
        put_bit(last);
    endtask : rbyte
    task automatic read_word(input logic [6:0] a, input logic [7:0] cmd,
        output logic [15:0] v, output logic nak);
        logic n1, n2, n3;
        logic [7:0] lo, hi;
        start();
        wbyte({a, 1'b0}, n1);
        wbyte(cmd, n2);
        start();
        wbyte({a, 1'b1}, n3);
        rbyte(lo, 1'b0);
        rbyte(hi, 1'b1);
        stop();
        v = {hi, lo};
        nak = n1 | n2 | n3;
    endtask : read_word
    task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
        input logic [15:0] d, output logic nak);
        logic n1, n2, n3, n4;
        start();
        wbyte({a, 1'b0}, n1);
        wbyte(cmd, n2);
        wbyte(d[7:0], n3);
        wbyte(d[15:8], n4);
        stop();
        nak = n1 | n2 | n3 | n4;
    endtask : write_word
endmodule : cst_host_model

// File: cst_pkg.sv
package cst_pkg;

    typedef enum logic [3:0] {
        CST_IDLE,
        CST_ADDR,
        CST_ADDR_ACK,
        CST_CMD,
        CST_CMD_ACK,
        CST_WDATA,
        CST_WDATA_ACK,
        CST_RDATA,
        CST_RACK
    } cst_state_e_t;

    typedef struct packed {
        cst_state_e_t fsm;
        logic [3:0] bit_cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [7:0] cmd;
        logic is_read;
        logic more;
        logic [1:0] byte_sel;
        logic [15:0] snap;
        logic sda_oe;
        logic sda_out;
        logic scl_prev;
        logic sda_prev;
        logic [7:0][15:0] telem;
        logic questionable;
        logic ntc_open;
    } cst_top_t;

endpackage : cst_pkg

// File: cst_sync.sv
`timescale 1ns/100ps
module cst_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // raw pins in, settled copies out
    cst_sync_if.sync port
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cst_sync_t;

    cst_sync_t q;
    cst_sync_t next_q;

    // the first stage feeds only the second stage
    always_comb begin
        next_q.meta = port.raw;
        next_q.stable = q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            // the bus lines idle high; a cleared chain would fake edges after reset
            q <= '1;
        end else begin
            q <= next_q;
        end
    end

    assign port.synced = q.stable;
endmodule : cst_sync

// File: cst_sync_if.sv
`timescale 1ns/100ps
interface cst_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface : cst_sync_if

// File: cst_telemetry_regs.sv
`timescale 1ns/100ps
`include "cst_defs.svh"
module cst_telemetry_regs #(
    parameter logic [6:0] DEV_ADDR = `CST_I2C_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // two-wire host port, data line is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // live analog condition comparators
    input wire logic charger_enabled_i,
    input wire logic missing_freq_resistor_i,
    input wire logic thermal_shutdown_i,
    input wire logic input_ovlo_i,
    input wire logic input_above_battery_i,
    input wire logic input_above_uvlo_i,
    input wire logic internal_supply_ok_i,
    // conversion results from the measurement sequencer
    input wire logic telem_valid_i,
    input wire logic [2:0] telem_channel_i,
    input wire logic [15:0] telem_data_i,
    input wire logic [15:0] icharge_over_10_i,
    // derived flags
    output logic bsr_questionable_o,
    output logic ntc_open_o
);
    cst_pkg::cst_top_t q;
    cst_pkg::cst_top_t next_q;

    cst_sync_if #(.W(`CST_SY_WIDTH)) pins ();

    cst_sync #(
        .W(`CST_SY_WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .port(pins)
    );

    assign pins.raw = {
        charger_enabled_i,
        missing_freq_resistor_i,
        thermal_shutdown_i,
        input_ovlo_i,
        input_above_battery_i,
        input_above_uvlo_i,
        internal_supply_ok_i,
        sda_i,
        scl_i
    };

    logic scl;
    logic sda;
    logic chg_en;
    logic [5:0] cond;
    logic [5:0] live_status;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl = pins.synced[`CST_SY_SCL];
    assign sda = pins.synced[`CST_SY_SDA];
    assign chg_en = pins.synced[`CST_SY_CHG_EN];
    assign cond = pins.synced[`CST_SY_STATUS_LO +: 6];

    // edges are taken from the settled copies, never from the first stage
    assign scl_rise = scl && !q.scl_prev;
    assign scl_fall = !scl && q.scl_prev;
    assign start_seen = scl && q.scl_prev && !sda && q.sda_prev;
    assign stop_seen = scl && q.scl_prev && sda && !q.sda_prev;

    // live condition word, nothing latched
    always_comb begin
        live_status = cond;
        // resistor detection is meaningless while the charger is off
        live_status[`CST_ST_NO_FREQ_RES] = cond[`CST_ST_NO_FREQ_RES] || !chg_en;
        live_status[`CST_ST_THERMAL_SD] = cond[`CST_ST_THERMAL_SD];
        live_status[`CST_ST_INPUT_OVLO] = cond[`CST_ST_INPUT_OVLO];
        live_status[`CST_ST_IN_GT_BAT] = cond[`CST_ST_IN_GT_BAT];
        live_status[`CST_ST_IN_GT_UVLO] = cond[`CST_ST_IN_GT_UVLO];
        live_status[`CST_ST_INTSUP_OK] = cond[`CST_ST_INTSUP_OK];
    end

    // word presented for a command code; unmapped codes read zero
    function automatic logic [15:0] read_word(
        input logic [7:0] addr,
        input logic [7:0][15:0] t,
        input logic [5:0] st
    );
        logic [15:0] w;
        logic [7:0] idx;
        w = 16'h0000;
        idx = addr - `CST_TELEM_BASE;
        if (addr == `CST_STATUS_ADDR) begin
            w = {10'h000, st};
        end else if (addr >= `CST_TELEM_BASE && addr <= `CST_TELEM_LAST) begin
            w = t[idx[2:0]];
        end
        return w;
    endfunction : read_word

    // byte of the held snapshot, low byte first, then zeros
    function automatic logic [7:0] snap_byte(
        input logic [15:0] s,
        input logic [1:0] sel
    );
        logic [7:0] b;
        b = 8'h00;
        if (sel == 2'h0) begin
            b = s[7:0];
        end else if (sel == 2'h1) begin
            b = s[15:8];
        end
        return b;
    endfunction : snap_byte

    always_comb begin
        logic [7:0] first;
        logic [7:0] nxt;
        first = 8'h00;
        nxt = 8'h00;
        next_q = q;
        next_q.scl_prev = scl;
        next_q.sda_prev = sda;
        next_q.sda_out = 1'b0;

        // telemetry capture; the sequencer supplies battery drain as a
        // negative code while the charger is off, stored untouched
        if (telem_valid_i) begin
            next_q.telem[telem_channel_i] = telem_data_i;
        end
        // compare against the stored battery current, signed
        next_q.questionable =
            $signed(q.telem[`CST_CH_IBAT]) < $signed(icharge_over_10_i);
        next_q.ntc_open = (q.telem[`CST_CH_NTC] == `CST_OPEN_NTC_CODE);

        // host port sequencing
        if (start_seen) begin
            next_q.fsm = cst_pkg::CST_ADDR;
            next_q.bit_cnt = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_q.fsm = cst_pkg::CST_IDLE;
            next_q.sda_oe = 1'b0;
        end else begin
            case (q.fsm)
                cst_pkg::CST_IDLE: begin
                    next_q.sda_oe = 1'b0;
                end
                cst_pkg::CST_ADDR, cst_pkg::CST_CMD, cst_pkg::CST_WDATA: begin
                    if (scl_rise && q.bit_cnt != 4'h8) begin
                        next_q.rx = {q.rx[6:0], sda};
                        next_q.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall && q.bit_cnt == 4'h8) begin
                        next_q.bit_cnt = 4'h0;
                        if (q.fsm == cst_pkg::CST_ADDR) begin
                            if (q.rx[7:1] == DEV_ADDR) begin
                                next_q.sda_oe = 1'b1;
                                next_q.is_read = q.rx[0];
                                next_q.fsm = cst_pkg::CST_ADDR_ACK;
                                // one snapshot per read keeps both bytes coherent
                                next_q.snap = read_word(q.cmd, q.telem, live_status);
                                next_q.byte_sel = 2'h0;
                            end else begin
                                next_q.fsm = cst_pkg::CST_IDLE;
                            end
                        end else if (q.fsm == cst_pkg::CST_CMD) begin
                            next_q.cmd = q.rx;
                            next_q.sda_oe = 1'b1;
                            next_q.fsm = cst_pkg::CST_CMD_ACK;
                        end else begin
                            // every register here is read-only: data is acked and dropped
                            next_q.sda_oe = 1'b1;
                            next_q.fsm = cst_pkg::CST_WDATA_ACK;
                        end
                    end
                end
                cst_pkg::CST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (q.is_read) begin
                            first = snap_byte(q.snap, 2'h0);
                            next_q.sda_oe = !first[7];
                            next_q.tx = {first[6:0], 1'b0};
                            next_q.bit_cnt = 4'h1;
                            next_q.fsm = cst_pkg::CST_RDATA;
                        end else begin
                            next_q.sda_oe = 1'b0;
                            next_q.fsm = cst_pkg::CST_CMD;
                        end
                    end
                end
                cst_pkg::CST_CMD_ACK, cst_pkg::CST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_q.sda_oe = 1'b0;
                        next_q.fsm = cst_pkg::CST_WDATA;
                    end
                end
                cst_pkg::CST_RDATA: begin
                    if (scl_fall) begin
                        if (q.bit_cnt == 4'h8) begin
                            next_q.sda_oe = 1'b0;
                            next_q.fsm = cst_pkg::CST_RACK;
                        end else begin
                            next_q.sda_oe = !q.tx[7];
                            next_q.tx = {q.tx[6:0], 1'b0};
                            next_q.bit_cnt = q.bit_cnt + 4'h1;
                        end
                    end
                end
                cst_pkg::CST_RACK: begin
                    if (scl_rise) begin
                        next_q.more = !sda;
                    end else if (scl_fall) begin
                        if (q.more) begin
                            // saturate so bytes past the word read as zero
                            nxt = snap_byte(q.snap, q.byte_sel + 2'h1);
                            if (q.byte_sel != 2'h2) begin
                                next_q.byte_sel = q.byte_sel + 2'h1;
                            end
                            next_q.sda_oe = !nxt[7];
                            next_q.tx = {nxt[6:0], 1'b0};
                            next_q.bit_cnt = 4'h1;
                            next_q.fsm = cst_pkg::CST_RDATA;
                        end else begin
                            next_q.fsm = cst_pkg::CST_IDLE;
                        end
                    end
                end
                default: begin
                    next_q.fsm = cst_pkg::CST_IDLE;
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.fsm <= cst_pkg::CST_IDLE;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                q.telem[i] <= `CST_TELEM_RESET;
            end
        end else begin
            q <= next_q;
        end
    end

    assign sda_o = q.sda_out;
    assign sda_oe_o = q.sda_oe;
    assign bsr_questionable_o = q.questionable;
    assign ntc_open_o = q.ntc_open;
endmodule : cst_telemetry_regs

// File: cst_telemetry_regs_bench.sv
`timescale 1ns/100ps
module cst_telemetry_regs_bench;
    typedef struct packed {
        logic [2:0] ch;
        logic [15:0] data;
    } cst_row_t;
    localparam logic [6:0] DEV = 7'h2A;
    logic clk, reset, scl, host_oe, sda, dut_sda, dut_oe, valid, doubt, ntc_open, nak;
    logic [6:0] st, pat;
    logic [2:0] ch;
    logic [15:0] data, thr, v;
    logic [7:0] b0, b1, b2;
    int failures = 0;
    int comparisons = 0;
    cst_row_t rows [8] = '{'{3'h0, 16'h4E21}, '{3'h1, 16'h7FFF}, '{3'h2, 16'h8000},
        '{3'h3, 16'hFF38}, '{3'h4, 16'h0123}, '{3'h5, 16'h3039}, '{3'h6, 16'h54B4},
        '{3'h7, 16'hFFFF}};
    // pull-up on the data line; either party may only pull it low
    assign sda = ~(host_oe | (dut_oe & ~dut_sda));
    cst_host_model i_cst_host_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
    cst_telemetry_regs #(.DEV_ADDR(DEV)) i_cst_telemetry_regs (.clk_i(clk), .reset_i(reset),
        .scl_i(scl), .sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe),
        .charger_enabled_i(st[6]), .missing_freq_resistor_i(st[5]), .thermal_shutdown_i(st[4]),
        .input_ovlo_i(st[3]), .input_above_battery_i(st[2]), .input_above_uvlo_i(st[1]),
        .internal_supply_ok_i(st[0]), .telem_valid_i(valid), .telem_channel_i(ch),
        .telem_data_i(data), .icharge_over_10_i(thr), .bsr_questionable_o(doubt),
        .ntc_open_o(ntc_open));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic store(input logic [2:0] c, input logic [15:0] d);
        valid = 1'b1;
        ch = c;
        data = d;
        @(negedge clk);
        valid = 1'b0;
    endtask : store
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        i_cst_host_model.read_word(DEV, cmd, v, nak);
        check(v, exp);
        check({15'h0, nak}, 16'h0);
    endtask : rd
    task automatic bsr(input logic [15:0] d, input logic [15:0] t, input logic e);
        thr = t;
        store(3'h3, d);
        repeat (3) @(negedge clk);
        check({15'h0, doubt}, {15'h0, e});
    endtask : bsr
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        valid = 1'b0;
        ch = 3'h0;
        data = 16'h0;
        thr = 16'h0;
        st = 7'h40;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        foreach (rows[i]) begin
            store(rows[i].ch, rows[i].data);
            rd(8'h3A + {5'h0, rows[i].ch}, rows[i].data);
        end
        check({15'h0, ntc_open}, 16'h1);
        store(3'h6, 16'h54B3);
        repeat (3) @(negedge clk);
        check({15'h0, ntc_open}, 16'h0);
        for (int i = 0; i < 8; i++) begin
            pat = (i < 6) ? (7'h40 | (7'h01 << i)) : ((i == 6) ? 7'h00 : 7'h7F);
            st = pat;
            rd(8'h39, {10'h000, pat[5] | ~pat[6], pat[4:0]});
        end
        i_cst_host_model.write_word(DEV, 8'h39, 16'h0000, nak);
        check({15'h0, nak}, 16'h0);
        i_cst_host_model.write_word(DEV, 8'h3A, 16'hFFFF, nak);
        check({15'h0, nak}, 16'h0);
        rd(8'h39, 16'h003F);
        rd(8'h3A, 16'h4E21);
        // an unmapped code reads zero
        rd(8'h42, 16'h0000);
        // the one byte read past the word reads zero, not the low byte again
        i_cst_host_model.start();
        i_cst_host_model.wbyte({DEV, 1'b0}, nak);
        i_cst_host_model.wbyte(8'h3A, nak);
        i_cst_host_model.start();
        i_cst_host_model.wbyte({DEV, 1'b1}, nak);
        check({15'h0, nak}, 16'h0);
        i_cst_host_model.rbyte(b0, 1'b0);
        i_cst_host_model.rbyte(b1, 1'b0);
        i_cst_host_model.rbyte(b2, 1'b1);
        i_cst_host_model.stop();
        check({8'h00, b0}, 16'h0021);
        check({b2, b1}, 16'h004E);
        // host-side thermistor ohms from a reading
        check(16'(i_cst_host_model.ntc_ohms(32'h0000_2710, 32'h0000_1C6D)), 16'h1388);
        i_cst_host_model.read_word(7'h2B, 8'h3A, v, nak);
        check({15'h0, nak}, 16'h1);
        bsr(16'h0010, 16'h0020, 1'b1);
        bsr(16'h0020, 16'h0020, 1'b0);
        bsr(16'hFFFB, 16'h0001, 1'b1);
        bsr(16'h0001, 16'hFFFF, 1'b0);
        // new conversion lands during the low byte; the word must stay whole
        store(3'h1, 16'h1234);
        fork
            rd(8'h3B, 16'h1234);
            begin
                repeat (350) @(negedge clk);
                store(3'h1, 16'hABCD);
            end
        join
        rd(8'h3B, 16'hABCD);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        check({14'h0, doubt, ntc_open}, 16'h0);
        for (int i = 0; i < 8; i++) rd(8'h3A + i[7:0], 16'h0000);
        finish_test();
    end
endmodule : cst_telemetry_regs_bench

// File: cst_telemetry_regs_chk.sv
`timescale 1ns/100ps
`include "cst_defs.svh"
module cst_telemetry_regs_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // conversion results and flags
    input wire logic telem_valid_i,
    input wire logic [2:0] telem_channel_i,
    input wire logic [15:0] telem_data_i,
    input wire logic [15:0] icharge_over_10_i,
    input wire logic bsr_questionable_o,
    input wire logic ntc_open_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // a store followed by a cycle in which the same channel is left alone
    sequence s_ntc_new;
        telem_valid_i && telem_channel_i == 3'h6 ##1 !(telem_valid_i && telem_channel_i == 3'h6);
    endsequence
    sequence s_ibat_new;
        telem_valid_i && telem_channel_i == 3'h3 ##1 !(telem_valid_i && telem_channel_i == 3'h3);
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
        !sda_oe_o && !bsr_questionable_o && !ntc_open_o) else $error("outputs active after reset");
    a_ntc_open_code: assert property (s_ntc_new |=>
        ntc_open_o == ($past(telem_data_i, 2) == `CST_OPEN_NTC_CODE)) else $error("open flag wrong");
    a_ntc_open_hold: assert property (!(telem_valid_i && telem_channel_i == 3'h6) |->
        ##2 $stable(ntc_open_o)) else $error("open flag moved without a store");
    a_bsr_doubt: assert property (s_ibat_new |=> bsr_questionable_o ==
        ($signed($past(telem_data_i, 2)) < $signed($past(icharge_over_10_i))))
        else $error("doubt flag wrong");
    a_doubt_steady: assert property ((!(telem_valid_i && telem_channel_i == 3'h3)
        && $stable(icharge_over_10_i)) [*2] |=> $stable(bsr_questionable_o))
        else $error("doubt flag moved with no cause");
    a_drive_low_only: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    a_change_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    a_release_bound: assert property ($rose(sda_oe_o) |-> ##[1:200] !sda_oe_o)
        else $error("data line held too long");
endmodule : cst_telemetry_regs_chk

bind cst_telemetry_regs cst_telemetry_regs_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .telem_valid_i(telem_valid_i),
    .telem_channel_i(telem_channel_i), .telem_data_i(telem_data_i),
    .icharge_over_10_i(icharge_over_10_i), .bsr_questionable_o(bsr_questionable_o),
    .ntc_open_o(ntc_open_o));
